// *** rtl/mic_defines.vh ***
`ifndef MIC_DEFINES_VH
`define MIC_DEFINES_VH
`define MIC_OFS_EDGE 4'h0
`define MIC_OFS_CTLA 4'h4
`define MIC_OFS_CTLB 4'h8
`define MIC_OFS_CTLC 4'hc
`define MIC_OFS_STAT 4'h0
`define MIC_NSRC 8
`define MIC_SRC_PIN 0
`define MIC_SRC_TOUCH 1
`define MIC_SRC_CONV 2
`define MIC_SRC_CMPP 3
`define MIC_SRC_CMPA 4
`define MIC_SRC_TB0 5
`define MIC_SRC_TB1 6
`define MIC_SRC_EE 7
`define MIC_EDGE_OFF 2'h0
`define MIC_EDGE_RISE 2'h1
`define MIC_EDGE_FALL 2'h2
`define MIC_EDGE_BOTH 2'h3
`define MIC_VEC_BASE 12'h004
`define MIC_VEC_STEP 12'h004
`define MIC_RESET_BYTE 8'h00
`define MIC_RESP_OKAY 2'h0
`define MIC_RESP_SLVERR 2'h2
`endif

// *** rtl/mic_irq_ctrl.v ***
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`include "mic_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module mic_irq_ctrl (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire ext_irq_pin,
  input wire touch_slot_ovf,
  input wire conv_done,
  input wire cmp_p_match,
  input wire cmp_a_match,
  input wire tbase0_ovf,
  input wire tbase1_ovf,
  input wire eeprom_wr_done,
  input wire stack_full,
  input wire core_irq_ready,
  input wire [11:0] core_next_pc,
  input wire return_from_irq_instr,
  output reg irq_take,
  output reg [11:0] irq_vector,
  output reg [11:0] push_pc,
  output reg stack_pop,
  output reg wake_req
);
  reg [1:0] ext_edge_field_q;
  reg [7:0] flag_q;
  reg [7:0] flag_d;
  reg [7:0] en_q;
  reg [7:0] en_d;
  reg global_irq_enable_q;
  reg global_irq_enable_d;
  reg pin_prev_q;
  reg aw_held_q;
  reg [3:0] aw_addr_q;
  reg w_held_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  wire [7:0] event_v;
  wire pin_rise;
  wire pin_fall;
  reg pin_evt;
  wire [7:0] req_v;
  reg [7:0] grant;
  reg [2:0] grant_idx;
  integer i;
  wire do_write;
  reg [7:0] rd_byte;
  reg wr_hit;
  wire [7:0] edge_rd;
  wire [7:0] ctla_rd;
  wire [7:0] ctlb_rd;
  wire [7:0] ctlc_rd;

  assign pin_rise = ext_irq_pin & ~pin_prev_q;
  assign pin_fall = ~ext_irq_pin & pin_prev_q;

  always @* begin
    case (ext_edge_field_q)
      `MIC_EDGE_RISE: pin_evt = pin_rise;
      `MIC_EDGE_FALL: pin_evt = pin_fall;
      `MIC_EDGE_BOTH: pin_evt = pin_rise | pin_fall;
      default: pin_evt = 1'b0;
    endcase
  end

  assign event_v = {eeprom_wr_done, tbase1_ovf, tbase0_ovf, cmp_a_match,
                    cmp_p_match, conv_done, touch_slot_ovf, pin_evt};

  // request gating; no new take while a take is presented
  assign req_v = (global_irq_enable_q & ~stack_full & ~irq_take)
                 ? (flag_q & en_q) : 8'h00;

  always @* begin
    grant = 8'h00;
    grant_idx = 3'h0;
    for (i = `MIC_NSRC - 1; i >= 0; i = i - 1) begin
      if (req_v[i]) begin
        grant = 8'h00;
        grant[i] = 1'b1;
        grant_idx = i[2:0];
      end
    end
  end

  // axi write: address and data latched independently
  assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_write = aw_held_q & w_held_q & ~s_axi_bvalid;

  always @* begin
    wr_hit = (aw_addr_q == `MIC_OFS_EDGE) | (aw_addr_q == `MIC_OFS_CTLA) |
             (aw_addr_q == `MIC_OFS_CTLB) | (aw_addr_q == `MIC_OFS_CTLC);
  end

  // register writes, then hardware effects
  always @* begin
    flag_d = flag_q;
    en_d = en_q;
    global_irq_enable_d = global_irq_enable_q;
    if (do_write & w_strb_q[0]) begin
      case (aw_addr_q)
        `MIC_OFS_CTLA: begin
          flag_d[`MIC_SRC_CONV] = w_data_q[6];
          flag_d[`MIC_SRC_TOUCH] = w_data_q[5];
          flag_d[`MIC_SRC_PIN] = w_data_q[4];
          en_d[`MIC_SRC_CONV] = w_data_q[3];
          en_d[`MIC_SRC_TOUCH] = w_data_q[2];
          en_d[`MIC_SRC_PIN] = w_data_q[1];
          global_irq_enable_d = w_data_q[0];
        end
        `MIC_OFS_CTLB: begin
          flag_d[`MIC_SRC_CMPP] = w_data_q[7];
          flag_d[`MIC_SRC_TB1] = w_data_q[6];
          flag_d[`MIC_SRC_TB0] = w_data_q[5];
          flag_d[`MIC_SRC_EE] = w_data_q[4];
          en_d[`MIC_SRC_CMPP] = w_data_q[3];
          en_d[`MIC_SRC_TB1] = w_data_q[2];
          en_d[`MIC_SRC_TB0] = w_data_q[1];
          en_d[`MIC_SRC_EE] = w_data_q[0];
        end
        `MIC_OFS_CTLC: begin
          flag_d[`MIC_SRC_CMPA] = w_data_q[4];
          en_d[`MIC_SRC_CMPA] = w_data_q[0];
        end
        default: flag_d = flag_q;
      endcase
    end
    // service clears flag and global enable
    if (|grant) begin
      flag_d = flag_d & ~grant;
      global_irq_enable_d = 1'b0;
    end
    // events set flags, set beats clear
    flag_d = flag_d | event_v;
  end

  // edge field and pin history
  always @(posedge aclk) begin
    if (!aresetn) begin
      ext_edge_field_q <= `MIC_EDGE_OFF;
      pin_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= ext_irq_pin;
      if (do_write & w_strb_q[0] & (aw_addr_q == `MIC_OFS_EDGE)) begin
        ext_edge_field_q <= w_data_q[1:0];
      end
    end
  end

  // flags and enables; all sources already merged in flag_d
  always @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= `MIC_RESET_BYTE;
      en_q <= `MIC_RESET_BYTE;
      global_irq_enable_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      en_q <= en_d;
      global_irq_enable_q <= global_irq_enable_d;
    end
  end

  // write path: address and data may arrive in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_held_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MIC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read path: one read in flight, data registered
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `MIC_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end else begin
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= (s_axi_araddr[1:0] == 2'h0) ? `MIC_RESP_OKAY
                       : `MIC_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // core side; take stands until the core answers
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_take <= 1'b0;
      irq_vector <= 12'h000;
      push_pc <= 12'h000;
      stack_pop <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      // take with per-source vector; core acks with ready
      if (|grant) begin
        irq_take <= 1'b1;
        irq_vector <= `MIC_VEC_BASE + {9'h000, grant_idx} * `MIC_VEC_STEP;
        push_pc <= core_next_pc;
      end else if (irq_take & core_irq_ready) begin
        irq_take <= 1'b0;
      end
      stack_pop <= return_from_irq_instr;
      // wake on any flag newly set
      wake_req <= |(flag_d & ~flag_q);
    end
  end

  assign edge_rd = {6'h00, ext_edge_field_q};
  assign ctla_rd[7] = 1'b0;
  assign ctla_rd[6] = flag_q[`MIC_SRC_CONV];
  assign ctla_rd[5] = flag_q[`MIC_SRC_TOUCH];
  assign ctla_rd[4] = flag_q[`MIC_SRC_PIN];
  assign ctla_rd[3] = en_q[`MIC_SRC_CONV];
  assign ctla_rd[2] = en_q[`MIC_SRC_TOUCH];
  assign ctla_rd[1] = en_q[`MIC_SRC_PIN];
  assign ctla_rd[0] = global_irq_enable_q;
  assign ctlb_rd[7] = flag_q[`MIC_SRC_CMPP];
  assign ctlb_rd[6] = flag_q[`MIC_SRC_TB1];
  assign ctlb_rd[5] = flag_q[`MIC_SRC_TB0];
  assign ctlb_rd[4] = flag_q[`MIC_SRC_EE];
  assign ctlb_rd[3] = en_q[`MIC_SRC_CMPP];
  assign ctlb_rd[2] = en_q[`MIC_SRC_TB1];
  assign ctlb_rd[1] = en_q[`MIC_SRC_TB0];
  assign ctlb_rd[0] = en_q[`MIC_SRC_EE];
  assign ctlc_rd = {3'h0, flag_q[`MIC_SRC_CMPA], 3'h0, en_q[`MIC_SRC_CMPA]};

  always @* begin
    case (s_axi_araddr)
      `MIC_OFS_EDGE: rd_byte = edge_rd;
      `MIC_OFS_CTLA: rd_byte = ctla_rd;
      `MIC_OFS_CTLB: rd_byte = ctlb_rd;
      `MIC_OFS_CTLC: rd_byte = ctlc_rd;
      default: rd_byte = 8'h00;
    endcase
  end
endmodule // mic_irq_ctrl
`default_nettype wire

// *** tb/mic_irq_ctrl_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module mic_irq_ctrl_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic stack_full,
  input wire logic core_irq_ready,
  input wire logic [11:0] core_next_pc,
  input wire logic return_from_irq_instr,
  input wire logic irq_take,
  input wire logic [11:0] irq_vector,
  input wire logic [11:0] push_pc,
  input wire logic stack_pop
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_offer;
    !irq_take ##1 irq_take;
  endsequence
  sequence s_taken;
    irq_take && core_irq_ready;
  endsequence
  a_push_next: assert property (s_offer |->
    push_pc == $past(core_next_pc)) else $error("push pc wrong");
  a_vec_legal: assert property (irq_take |-> irq_vector[1:0] == 2'h0 &&
    irq_vector >= 12'h004 && irq_vector <= 12'h020) else $error("bad vector");
  a_full_blocks: assert property (stack_full && !irq_take |=>
    !irq_take) else $error("take while stack full");
  a_take_stands: assert property (irq_take && !core_irq_ready |=>
    irq_take && $stable(irq_vector)) else $error("take not held");
  a_take_once: assert property (s_taken |=> !irq_take [*2])
    else $error("second take without enable");
  a_pop_follows: assert property (return_from_irq_instr |=>
    stack_pop) else $error("no pop");
  a_pop_cause: assert property (stack_pop |->
    $past(return_from_irq_instr)) else $error("stray pop");
  a_pop_single: assert property (stack_pop |=> !stack_pop)
    else $error("pop too long");
endmodule // mic_irq_ctrl_chk
bind mic_irq_ctrl mic_irq_ctrl_chk u_chk (.aclk, .aresetn, .stack_full,
  .core_irq_ready, .core_next_pc, .return_from_irq_instr, .irq_take,
  .irq_vector, .push_pc, .stack_pop);
`default_nettype wire

// *** tb/mic_core_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module mic_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic irq_take,
  output logic core_irq_ready,
  output logic [11:0] core_next_pc,
  output logic return_from_irq_instr
);
  logic [2:0] wait_q;
  logic slow_q;
  always @(posedge aclk) begin
    core_next_pc <= aresetn ? core_next_pc + 12'h001 : 12'h100;
    core_irq_ready <= 1'b0;
    return_from_irq_instr <= 1'b0;
    wait_q <= irq_take && !core_irq_ready ? wait_q + 3'h1 : 3'h0;
    // alternate prompt and slow acceptance
    if (irq_take && !core_irq_ready && wait_q == (slow_q ? 3'h5 : 3'h0)) begin
      core_irq_ready <= 1'b1;
      slow_q <= !slow_q;
    end
    if (core_irq_ready) begin
      return_from_irq_instr <= 1'b1;
    end
    if (!aresetn) begin
      slow_q <= 1'b0;
    end
  end
endmodule // mic_core_model
`default_nettype wire

// *** tb/test_mcu_interrupt_controller.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_mcu_interrupt_controller;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, ext_irq_pin;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic touch_slot_ovf, conv_done, cmp_p_match, cmp_a_match, tbase0_ovf;
  logic tbase1_ovf, eeprom_wr_done, stack_full, core_irq_ready, irq_take;
  logic return_from_irq_instr, stack_pop, wake_req;
  logic [11:0] core_next_pc, irq_vector, push_pc;
  logic [7:0] ctla;
  int err_total, n_tests, wakes;
  mic_irq_ctrl u_mic_irq_ctrl (.*);
  mic_core_model u_mic_core_model (.*);
  initial begin
    aclk = 0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) if (wake_req === 1'b1) wakes++;
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, string nm);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
    chk(nm, s_axi_rdata, {24'h0, e});
  endtask
  task automatic wait_take(input logic v);
    for (int i = 0; i < 30 && irq_take !== v; i++) @(posedge aclk);
  endtask
  task automatic test_regs;
    logic [7:0] ex [4] = '{8'h03, 8'h7e, 8'hff, 8'h11};
    for (int i = 0; i < 4; i++) rd(4'(4 * i), 0, "reset");
    for (int i = 0; i < 4; i++) begin
      wr(4'(4 * i), i == 1 ? 8'hfe : 8'hff);
      rd(4'(4 * i), ex[i], "map");
      wr(4'(4 * i), 0);
      rd(4'(4 * i), 0, "clear");
    end
    rd(4'h2, 0, "misaligned");
    $display("test regs done");
  endtask
  task automatic test_events;
    int w0;
    ext_irq_pin <= 1;
    wr(4'h0, 8'h01);
    wr(4'h8, 8'h0f);
    wr(4'hc, 8'h01);
    wr(4'h4, 8'h0e);
    {ext_irq_pin, touch_slot_ovf, conv_done, cmp_p_match} <= 4'h0;
    {cmp_a_match, tbase0_ovf, tbase1_ovf, eeprom_wr_done} <= 4'h0;
    @(posedge aclk);
    w0 = wakes;
    ext_irq_pin <= 1;
    {touch_slot_ovf, conv_done, cmp_p_match, cmp_a_match} <= 4'hf;
    {tbase0_ovf, tbase1_ovf, eeprom_wr_done} <= 3'h7;
    @(posedge aclk);
    {touch_slot_ovf, conv_done, cmp_p_match, cmp_a_match} <= 4'h0;
    {tbase0_ovf, tbase1_ovf, eeprom_wr_done} <= 3'h0;
    rd(4'h4, 8'h7e, "pending");
    rd(4'h8, 8'hff, "pending b");
    chk("idle", irq_take, 0);
    chk("wake", wakes != w0, 1);
    ctla = 8'h7e;
    stack_full <= 1;
    for (int k = 0; k < 8; k++) begin
      wr(4'h4, ctla | 8'h01);
      if (k == 0) begin
        repeat (5) @(posedge aclk);
        chk("full", irq_take, 0);
        stack_full <= 0;
      end
      wait_take(1);
      chk("vector", irq_vector, 12'h004 + 12'(4 * k));
      wait_take(0);
      if (k < 3) ctla = ctla & ~(8'h10 << k);
    end
    rd(4'h4, 8'h0e, "serviced a");
    rd(4'h8, 8'h0f, "serviced b");
    rd(4'hc, 8'h01, "serviced c");
    wr(4'h4, 8'h71);
    repeat (3) @(posedge aclk);
    chk("masked", irq_take, 0);
    rd(4'h4, 8'h71, "masked flags");
    $display("test events done");
  endtask
  task automatic test_edges;
    wr(4'h4, 0);
    for (int m = 0; m < 4; m++) begin
      wr(4'h0, 8'(m));
      ext_irq_pin <= !ext_irq_pin;
      repeat (3) @(posedge aclk);
      rd(4'h4, m == 0 ? 8'h00 : 8'h10, "edge");
      wr(4'h4, 0);
    end
    $display("test edges done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 0;
    {s_axi_wdata, ext_irq_pin, touch_slot_ovf, conv_done} = 0;
    {cmp_p_match, cmp_a_match, tbase0_ovf, tbase1_ovf} = 0;
    {eeprom_wr_done, stack_full} = 0;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    test_regs();
    test_events();
    test_edges();
    summarize();
  end
  initial begin
    repeat (5000) @(posedge aclk);
    err_total++;
    summarize();
  end
endmodule // test_mcu_interrupt_controller
`default_nettype wire
